/* File: rtl/bep_pkg.sv */
// Contract
// - Read: load pointer, then read byte
// - Write: load pointer, then data latch
// - Selected read, byte path, idle: byte out
// - Selected read, status path: status out
// - Selected write, pointer path: strobe loads pointer
// - Selected write, latch path: strobe loads latch
package bep_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned WRITE_BUSY_MAX_US = 25000;
  localparam int unsigned CLEAR_BUSY_MAX_US = 12500;
  localparam int unsigned WRITE_BUSY_CYC = WRITE_BUSY_MAX_US * (CLK_HZ / 1000000);
  localparam int unsigned CLEAR_BUSY_CYC = CLEAR_BUSY_MAX_US * (CLK_HZ / 1000000);
  localparam int unsigned PHASE_CYC = 4;
  localparam logic [3:0] PHASE_LAST = 4'h3;
  localparam logic [3:0] STROBE_RISE = 4'h2;
  localparam logic [2:0] ADDR_CMD = 3'h0;
  localparam logic [2:0] ADDR_ADR = 3'h1;
  localparam logic [2:0] ADDR_DAT = 3'h2;
  localparam logic [2:0] ADDR_STAT = 3'h3;
  localparam logic [2:0] ADDR_IRQ = 3'h4;
  localparam logic [2:0] ADDR_MASK = 3'h5;
  localparam logic [2:0] ADDR_RDATA = 3'h6;
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_STAT = 2'h2;
  localparam logic [1:0] CMD_CLEAR = 2'h3;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_TMO = 1;
  localparam int unsigned IRQ_W = 2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int unsigned STAT_BUSY_BIT = 7;
  typedef enum logic [2:0] {
    BEP_IDLE, BEP_ADR, BEP_ACC, BEP_WAIT, BEP_DONE
  } bep_state_t;
endpackage : bep_pkg

/* File: rtl/bep_phase.sv */
`timescale 1ns/10ps
`default_nettype none
module bep_phase (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Control
  input wire logic run_in,
  output logic last_out,
  output logic strobe_out
);
  import bep_pkg::*;
  logic [3:0] cnt_r;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_r <= 4'h0;
    end else if (!run_in || cnt_r == PHASE_LAST) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  // Strobe rises midway so data and selects are settled before the edge
  assign strobe_out = run_in && (cnt_r >= STROBE_RISE);
  assign last_out = run_in && (cnt_r == PHASE_LAST);
endmodule : bep_phase
`default_nettype wire

/* File: rtl/bep_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module bep_timer #(
  parameter int unsigned LIMIT = 250000
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Control
  input wire logic run_in,
  output logic expired_out
);
  logic [17:0] cnt_r;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_r <= 18'h00000;
    end else if (!run_in) begin
      cnt_r <= 18'h00000;
    end else if (!expired_out) begin
      cnt_r <= cnt_r + 18'h00001;
    end
  end
  assign expired_out = run_in && (cnt_r >= 18'(LIMIT));
endmodule : bep_timer
`default_nettype wire

/* File: rtl/bep_host.sv */
`timescale 1ns/10ps
`default_nettype none
module bep_host #(
  parameter int unsigned WRITE_LIMIT = bep_pkg::WRITE_BUSY_CYC,
  parameter int unsigned CLEAR_LIMIT = bep_pkg::CLEAR_BUSY_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Software port
  input wire logic [2:0] sw_addr_in,
  input wire logic [7:0] sw_wdata_in,
  input wire logic sw_wr_in,
  input wire logic sw_rd_in,
  output logic [7:0] sw_rdata_out,
  output logic irq_out,
  // Device pins
  input wire logic [7:0] dev_data_in,
  output logic [7:0] dev_data_out,
  output logic dev_data_oe_n_out,
  output logic dev_cs_n_out,
  output logic dev_rw_out,
  output logic register_select_out,
  output logic load_strobe_out,
  output logic array_clear_n_out,
  input wire logic dev_busy_n_in
);
  import bep_pkg::*;
  bep_state_t state_r;
  logic [1:0] cmd_r;
  logic [7:0] adr_r;
  logic [7:0] dat_r;
  logic [7:0] rdata_r;
  logic [7:0] stat_r;
  logic [IRQ_W-1:0] irq_r;
  logic [IRQ_W-1:0] mask_r;
  logic [IRQ_W-1:0] ev;
  logic [7:0] sw_rdata_r;
  logic run;
  logic last;
  logic strobe;
  logic wait_wr;
  logic wait_blk;
  logic tmo_wr;
  logic tmo_blk;
  logic start;
  logic waits;
  logic is_acc;
  logic is_adr;

  assign start = sw_wr_in && sw_addr_in == ADDR_CMD && state_r == BEP_IDLE;
  assign is_adr = state_r == BEP_ADR;
  assign is_acc = state_r == BEP_ACC;
  assign run = is_adr || is_acc;
  assign waits = state_r == BEP_WAIT;
  assign wait_wr = waits && cmd_r == CMD_WRITE;
  assign wait_blk = waits && cmd_r == CMD_CLEAR;

  bep_phase u_phase (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .run_in(run),
    .last_out(last),
    .strobe_out(strobe)
  );
  bep_timer #(.LIMIT(WRITE_LIMIT)) u_twr (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .run_in(wait_wr),
    .expired_out(tmo_wr)
  );
  bep_timer #(.LIMIT(CLEAR_LIMIT)) u_tclr (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .run_in(wait_blk),
    .expired_out(tmo_blk)
  );

  // Sequencer; pointer load only for read and write
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= BEP_IDLE;
    end else begin
      case (state_r)
        BEP_IDLE: begin
          if (start) begin
            if (sw_wdata_in[1:0] == CMD_READ || sw_wdata_in[1:0] == CMD_WRITE) begin
              state_r <= BEP_ADR;
            end else begin
              state_r <= BEP_ACC;
            end
          end
        end
        BEP_ADR: begin
          if (last) begin
            state_r <= BEP_ACC;
          end
        end
        BEP_ACC: begin
          if (last) begin
            if (cmd_r == CMD_WRITE || cmd_r == CMD_CLEAR) begin
              state_r <= BEP_WAIT;
            end else begin
              state_r <= BEP_DONE;
            end
          end
        end
        BEP_WAIT: begin
          // No new access until busy releases, or timeout gives up
          if (dev_busy_n_in || tmo_wr || tmo_blk) begin
            state_r <= BEP_DONE;
          end
        end
        BEP_DONE: state_r <= BEP_IDLE;
        default: state_r <= BEP_IDLE;
      endcase
    end
  end

  // Command fields; held stable while the device works
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_r <= CMD_READ;
      adr_r <= BYTE_ZERO;
      dat_r <= BYTE_ZERO;
    end else begin
      if (start) begin
        cmd_r <= sw_wdata_in[1:0];
      end
      if (sw_wr_in && sw_addr_in == ADDR_ADR && state_r == BEP_IDLE) begin
        adr_r <= sw_wdata_in;
      end
      if (sw_wr_in && sw_addr_in == ADDR_DAT && state_r == BEP_IDLE) begin
        dat_r <= sw_wdata_in;
      end
    end
  end

  // Sample device data at the end of a read phase
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= BYTE_ZERO;
      stat_r <= BYTE_ZERO;
    end else if (is_acc && last) begin
      if (cmd_r == CMD_READ) begin
        rdata_r <= dev_data_in;
      end else if (cmd_r == CMD_STAT) begin
        stat_r <= dev_data_in;
      end
    end
  end

  // Pin decode from state and command
  always_comb begin
    dev_cs_n_out = !run;
    dev_rw_out = 1'b1;
    register_select_out = 1'b0;
    load_strobe_out = 1'b0;
    array_clear_n_out = 1'b1;
    dev_data_oe_n_out = 1'b1;
    dev_data_out = BYTE_ZERO;
    if (is_adr) begin
      dev_rw_out = 1'b0;
      load_strobe_out = strobe;
      dev_data_oe_n_out = 1'b0;
      dev_data_out = adr_r;
    end else if (is_acc) begin
      case (cmd_r)
        CMD_READ: begin
          register_select_out = 1'b0;
        end
        CMD_WRITE: begin
          dev_rw_out = 1'b0;
          register_select_out = 1'b1;
          load_strobe_out = strobe;
          dev_data_oe_n_out = 1'b0;
          dev_data_out = dat_r;
        end
        CMD_STAT: begin
          register_select_out = 1'b1;
        end
        CMD_CLEAR: begin
          register_select_out = 1'b1;
          load_strobe_out = strobe;
          array_clear_n_out = 1'b0;
        end
        default: begin
          register_select_out = 1'b0;
        end
      endcase
    end
  end

  // Events: done and timeout; set beats clear
  assign ev[IRQ_DONE] = state_r == BEP_DONE;
  assign ev[IRQ_TMO] = waits && (tmo_wr || tmo_blk);
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_r <= '0;
      mask_r <= '0;
    end else begin
      if (sw_wr_in && sw_addr_in == ADDR_IRQ) begin
        irq_r <= (irq_r & ~sw_wdata_in[IRQ_W-1:0]) | ev;
      end else begin
        irq_r <= irq_r | ev;
      end
      if (sw_wr_in && sw_addr_in == ADDR_MASK) begin
        mask_r <= sw_wdata_in[IRQ_W-1:0];
      end
    end
  end
  assign irq_out = |(irq_r & mask_r);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sw_rdata_r <= BYTE_ZERO;
    end else if (sw_rd_in) begin
      case (sw_addr_in)
        ADDR_CMD: sw_rdata_r <= {5'h00, state_r != BEP_IDLE, cmd_r};
        ADDR_ADR: sw_rdata_r <= adr_r;
        ADDR_DAT: sw_rdata_r <= dat_r;
        ADDR_STAT: sw_rdata_r <= stat_r;
        ADDR_IRQ: sw_rdata_r <= {6'h00, irq_r};
        ADDR_MASK: sw_rdata_r <= {6'h00, mask_r};
        ADDR_RDATA: sw_rdata_r <= rdata_r;
        default: sw_rdata_r <= BYTE_ZERO;
      endcase
    end else begin
      sw_rdata_r <= BYTE_ZERO;
    end
  end
  assign sw_rdata_out = sw_rdata_r;

  // Pin checks; a strobe edge must see settled selects and data
  AST_DESELECT_HIZ: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    dev_cs_n_out |-> dev_data_oe_n_out && !load_strobe_out)
    else $error("driving while deselected");
  AST_PTR_LOAD: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (is_adr && load_strobe_out) |-> !dev_rw_out && !register_select_out && !dev_data_oe_n_out
    && dev_data_out == adr_r)
    else $error("bad pointer load pins");
  AST_LATCH_LOAD: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (is_acc && cmd_r == CMD_WRITE && load_strobe_out) |-> !dev_rw_out && register_select_out
    && array_clear_n_out && !dev_data_oe_n_out && dev_data_out == dat_r)
    else $error("bad data latch load pins");
  AST_BYTE_READ: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (is_acc && cmd_r == CMD_READ) |-> dev_rw_out && !register_select_out
    && array_clear_n_out && !load_strobe_out)
    else $error("bad byte read pins");
  AST_STAT_READ: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (is_acc && cmd_r == CMD_STAT) |-> dev_rw_out && register_select_out
    && array_clear_n_out && dev_data_oe_n_out)
    else $error("bad status read pins");
  AST_CLEAR_PINS: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !array_clear_n_out |-> dev_rw_out && register_select_out && dev_data_oe_n_out)
    else $error("bad clear pins");
  AST_CLEAR_STROBE: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (is_acc && cmd_r == CMD_CLEAR) |-> !array_clear_n_out && dev_rw_out && register_select_out)
    else $error("clear phase without clear pins");
  AST_READ_RELEASES: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    dev_rw_out |-> dev_data_oe_n_out)
    else $error("host drives port during read");
  AST_STROBE_SETTLED: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(load_strobe_out) |-> $stable(dev_rw_out) && $stable(register_select_out)
    && $stable(array_clear_n_out) && $stable(dev_data_out))
    else $error("pins moved at strobe rise");
  AST_STROBE_ENDS: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $fell(load_strobe_out) |-> $past(last))
    else $error("strobe dropped inside a phase");
  // Sequencing checks
  AST_ADR_BEFORE_WRITE: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (is_acc && cmd_r == CMD_WRITE && $rose(is_acc)) |-> $past(is_adr))
    else $error("data latch load without pointer load");
  AST_READ_ADR_FIRST: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (is_acc && cmd_r == CMD_READ && $rose(is_acc)) |-> $past(is_adr))
    else $error("byte read without pointer load");
  AST_STAT_NO_ADR: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (is_acc && cmd_r == CMD_STAT && $rose(is_acc)) |-> !$past(is_adr))
    else $error("status read preceded by pointer load");
  AST_CLEAR_NO_ADR: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (is_acc && cmd_r == CMD_CLEAR && $rose(is_acc)) |-> !$past(is_adr))
    else $error("clear preceded by pointer load");
  AST_NO_ACCESS_BUSY: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    waits |-> dev_cs_n_out)
    else $error("access during device busy");
  AST_WRITE_WAIT: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (is_acc && last && cmd_r == CMD_WRITE) |=> waits)
    else $error("write not followed by busy wait");
  AST_CLEAR_WAIT: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (is_acc && last && cmd_r == CMD_CLEAR) |=> waits)
    else $error("clear not followed by busy wait");
  AST_WAIT_HOLDS: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    waits |-> $stable(cmd_r) && $stable(adr_r) && $stable(dat_r))
    else $error("command fields moved while waiting");
  AST_BUSY_EXIT: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (waits && dev_busy_n_in) |=> state_r == BEP_DONE)
    else $error("wait not ended by busy release");
  AST_TMO_EXIT: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (waits && (tmo_wr || tmo_blk)) |=> state_r == BEP_DONE)
    else $error("wait not ended by timeout");
  AST_DONE_ONE: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state_r == BEP_DONE |=> state_r == BEP_IDLE)
    else $error("done state longer than one cycle");
endmodule : bep_host
`default_nettype wire

/* File: testbench/bep_dev_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bep_dev_model #(
  parameter int WR_CYC = 20,
  parameter int CLR_CYC = 12
) (
  // Clock and test knob
  input wire logic clk_in,
  input wire logic stall_in,
  // Device pins
  input wire logic cs_n_in,
  input wire logic rw_in,
  input wire logic register_select_in,
  input wire logic strobe_in,
  input wire logic array_clear_n_in,
  input wire logic [7:0] d_in,
  output logic [7:0] d_out,
  output logic busy_n_out
);
  logic [7:0] mem [256];
  logic [7:0] ptr = 8'h00;
  logic [7:0] last = 8'h00;
  logic stb_q = 1'b0;
  logic wipe_op = 1'b0;
  int cnt = 0;
  wire rise = strobe_in & !stb_q & !cs_n_in;
  wire busy = (cnt != 0);
  wire rd = !cs_n_in & rw_in & array_clear_n_in & (register_select_in | !busy);
  wire [7:0] val = register_select_in ? {busy, 7'h00} : mem[ptr];
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // Released port shows the inverse so a stale sample cannot pass
  assign d_out = rd ? val : ~last;
  assign busy_n_out = !busy;
  always @(posedge clk_in) begin
    stb_q <= strobe_in;
    if (rd) last <= val;
    if (busy) begin
      cnt <= cnt - 1;
      if (cnt == 1 && wipe_op) foreach (mem[i]) mem[i] <= 8'h00;
    end else if (rise && array_clear_n_in && !rw_in && !register_select_in) begin
      ptr <= d_in;
    end else if (rise && array_clear_n_in && !rw_in && register_select_in) begin
      mem[ptr] <= d_in;
      wipe_op <= 1'b0;
      cnt <= stall_in ? 100 : WR_CYC;
    end else if (rise && !array_clear_n_in && rw_in && register_select_in) begin
      wipe_op <= 1'b1;
      cnt <= stall_in ? 100 : CLR_CYC;
    end
  end
endmodule : bep_dev_model
`default_nettype wire

/* File: testbench/byte_eeprom_host_port_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module byte_eeprom_host_port_bench;
  import bep_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [2:0] sw_addr_in = 3'h0;
  logic [7:0] sw_wdata_in = 8'h00;
  logic sw_wr_in = 1'b0;
  logic sw_rd_in = 1'b0;
  logic stall = 1'b0;
  logic [7:0] sw_rdata_out, dev_data_in, dev_data_out, v;
  logic irq_out, oe_n, cs_n, rw, regsel, stb, wipe_n, busy_n;
  int miscompares = 0;
  int n_checks = 0;
  bep_host #(.WRITE_LIMIT(50), .CLEAR_LIMIT(30)) bep_host_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .sw_addr_in(sw_addr_in),
    .sw_wdata_in(sw_wdata_in), .sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in),
    .sw_rdata_out(sw_rdata_out), .irq_out(irq_out), .dev_data_in(dev_data_in),
    .dev_data_out(dev_data_out), .dev_data_oe_n_out(oe_n), .dev_cs_n_out(cs_n),
    .dev_rw_out(rw), .register_select_out(regsel), .load_strobe_out(stb),
    .array_clear_n_out(wipe_n), .dev_busy_n_in(busy_n));
  bep_dev_model bep_dev_model_i (
    .clk_in(clk_in), .stall_in(stall), .cs_n_in(cs_n), .rw_in(rw),
    .register_select_in(regsel), .strobe_in(stb), .array_clear_n_in(wipe_n),
    .d_in(dev_data_out), .d_out(dev_data_in),
    .busy_n_out(busy_n));
  initial forever #50 clk_in = ~clk_in;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    sw_addr_in <= a;
    sw_wdata_in <= d;
    sw_wr_in <= 1'b1;
    @(posedge clk_in);
    sw_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge clk_in);
    sw_addr_in <= a;
    sw_rd_in <= 1'b1;
    @(posedge clk_in);
    sw_rd_in <= 1'b0;
    #1 v = sw_rdata_out;
  endtask : rd
  // Waits for the interrupt, checks the masked cause bits, then clears them
  task automatic wait_irq(input logic [7:0] m, input logic [7:0] exp);
    int k;
    for (k = 0; k < 600 && irq_out !== 1'b1; k++) @(posedge clk_in);
    if (k == 600) begin
      miscompares++;
      $display("BAD %0t no interrupt", $time);
      print_verdict();
    end
    rd(ADDR_IRQ);
    chk(v & m, exp);
    wr(ADDR_IRQ, 8'h03);
  endtask : wait_irq
  task automatic op(input logic [1:0] c);
    wr(ADDR_CMD, {6'h00, c});
    wait_irq(8'h03, 8'h01);
  endtask : op
  task automatic fetch(input logic [7:0] a, input logic [7:0] exp);
    wr(ADDR_ADR, a);
    op(CMD_READ);
    rd(ADDR_RDATA);
    chk(v, exp);
  endtask : fetch
  initial begin
    repeat (8) @(posedge clk_in);
    chk({cs_n, oe_n, stb, wipe_n, irq_out, 3'h0}, 8'hD0);
    reset_n_in <= 1'b1;
    rd(ADDR_CMD);
    chk(v, 8'h00);
    rd(3'h7);
    chk(v, 8'h00);
    wr(ADDR_MASK, 8'h03);
    wr(ADDR_ADR, 8'h10);
    wr(ADDR_DAT, 8'h5A);
    op(CMD_WRITE);
    chk(bep_dev_model_i.mem[16], 8'h5A);
    fetch(8'h10, 8'h5A);
    fetch(8'h11, 8'hFF);
    op(CMD_STAT);
    rd(ADDR_STAT);
    chk(v, 8'h00);
    wr(ADDR_ADR, 8'h20);
    wr(ADDR_DAT, 8'h33);
    wr(ADDR_CMD, {6'h00, CMD_WRITE});
    wr(ADDR_CMD, {6'h00, CMD_READ});
    rd(ADDR_CMD);
    chk(v & 8'h07, 8'h05);
    wait_irq(8'h03, 8'h01);
    fetch(8'h20, 8'h33);
    op(CMD_CLEAR);
    fetch(8'h10, 8'h00);
    stall <= 1'b1;
    wr(ADDR_CMD, {6'h00, CMD_WRITE});
    wait_irq(8'h02, 8'h02);
    stall <= 1'b0;
    repeat (120) @(posedge clk_in);
    stall <= 1'b1;
    wr(ADDR_CMD, {6'h00, CMD_CLEAR});
    wait_irq(8'h02, 8'h02);
    stall <= 1'b0;
    repeat (120) @(posedge clk_in);
    wr(ADDR_MASK, 8'h00);
    wr(ADDR_CMD, {6'h00, CMD_STAT});
    repeat (40) @(posedge clk_in);
    chk({7'h00, irq_out}, 8'h00);
    rd(ADDR_IRQ);
    chk(v, 8'h01);
    wr(ADDR_MASK, 8'h01);
    @(posedge clk_in);
    chk({7'h00, irq_out}, 8'h01);
    wr(ADDR_IRQ, 8'h01);
    @(posedge clk_in);
    chk({7'h00, irq_out}, 8'h00);
    print_verdict();
  end
endmodule : byte_eeprom_host_port_bench
`default_nettype wire
